// ==== core/nco_edge_pick.sv ====
// Clock source selector and rising edge detector for the counting clock
`include "nco_params.svh"
module nco_edge_pick (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic [1:0] clock_source_select,
    input  wire logic       external_clock_pin,
    input  wire logic       internal_fast_oscillator,
    input  wire logic       logic_cell_output,
    output logic            tick
);
    logic src;
    logic prev_reg;

    // Mux the source; system clock source ticks every cycle
    always_comb begin
        case (clock_source_select)
            `NCO_CKS_PIN:  src = external_clock_pin;
            `NCO_CKS_FAST: src = internal_fast_oscillator;
            `NCO_CKS_CELL: src = logic_cell_output;
            default:       src = 1'b0;
        endcase
    end

    // Remember last level to find rising edges
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= src;
        end
    end

    // Inputs are synchronous, so a plain edge compare is safe
    assign tick = (clock_source_select == `NCO_CKS_SYS) ? 1'b1
                                                        : (src & ~prev_reg);
endmodule : nco_edge_pick

// ==== core/nco_params.svh ====
// Offsets, field positions, reset values and clock source codes for the oscillator block
`ifndef NCO_PARAMS_SVH
`define NCO_PARAMS_SVH

// Register offsets on the plain register port
`define NCO_OFS_ACCL      3'h0
`define NCO_OFS_ACCH      3'h1
`define NCO_OFS_ACCU      3'h2
`define NCO_OFS_STEPL     3'h3
`define NCO_OFS_STEPH     3'h4
`define NCO_OFS_CTRL      3'h5
`define NCO_OFS_CLKSET    3'h6
`define NCO_OFS_IRQ       3'h7

// Reset values
`define NCO_RST_ACC       20'h00000
`define NCO_RST_STEP      16'h0001
`define NCO_RST_BYTE      8'h00

// Control register fields
`define NCO_CTRL_EN       7
`define NCO_CTRL_OE       6
`define NCO_CTRL_OUT      5
`define NCO_CTRL_POL      4
`define NCO_CTRL_PFM      0

// Clock setup register fields
`define NCO_CLK_PWS_HI    7
`define NCO_CLK_PWS_LO    5
`define NCO_CLK_CKS_HI    1
`define NCO_CLK_CKS_LO    0

// Writable bits of the control and clock setup bytes
`define NCO_CTRL_WMASK    8'hD1
`define NCO_CLK_WMASK     8'hE3

// Interrupt register fields: status bit 0, mask bit 4
`define NCO_IRQ_FLAG      0
`define NCO_IRQ_MASK      4

// Clock source codes
`define NCO_CKS_PIN       2'h0
`define NCO_CKS_SYS       2'h1
`define NCO_CKS_FAST      2'h2
`define NCO_CKS_CELL      2'h3

// Accumulator geometry
`define NCO_ACC_MSB       19
`define NCO_UPPER_MSB     3

`endif

// ==== core/nco_phase_accumulator_regs.sv ====
// Numerically controlled oscillator: registers, accumulator, interrupt
//
// Operation
// - 20-bit accumulator readable, writable as three bytes
// - Upper byte bits 7..4 read zero
// - 16-bit step readable, writable as two bytes
// - Step resets to one
// - Accumulator high, upper, step high reset zero
// - Pulse width only matters in pulse mode
// - Two-bit field picks counting clock source
// - Pulse width is two-power count of ticks
// - Mode bit picks fixed duty or pulse
// - Counts independently of processor sleep state
//
// The register offsets and the strobed register port are this design's own decisions.
`include "nco_params.svh"
module nco_phase_accumulator_regs (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic [2:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       external_clock_pin,
    input  wire logic       internal_fast_oscillator,
    input  wire logic       logic_cell_output,
    input  wire logic       cpu_sleep,
    output logic            osc_out,
    output logic            osc_out_oe_n,
    output logic            irq
);
    nco_pkg::nco_bus_req_t req;
    nco_pkg::nco_cfg_t     cfg;
    logic [19:0] acc_reg;
    logic [15:0] step_reg;
    logic [7:0]  ctrl_reg;
    logic [7:0]  clkset_reg;
    logic        flag_reg;
    logic        mask_reg;
    logic [7:0]  rdata_next;
    logic [20:0] sum;
    logic        tick;
    logic        ovf;
    logic        level;
    logic        out_level;
    logic        acc_wr;

    // Bundle the bus request
    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    // Decode the configuration fields
    assign cfg.enable               = ctrl_reg[`NCO_CTRL_EN];
    assign cfg.pin_drive_enable     = ctrl_reg[`NCO_CTRL_OE];
    assign cfg.output_polarity      = ctrl_reg[`NCO_CTRL_POL];
    assign cfg.pulse_frequency_mode = ctrl_reg[`NCO_CTRL_PFM];
    assign cfg.pulse_width_select   =
        clkset_reg[`NCO_CLK_PWS_HI:`NCO_CLK_PWS_LO];
    assign cfg.clock_source_select  =
        clkset_reg[`NCO_CLK_CKS_HI:`NCO_CLK_CKS_LO];

    // Write hit test, used by several processes
    function automatic logic hit(input nco_pkg::nco_bus_req_t r,
                                 input logic [2:0] ofs);
        hit = r.wr && (r.addr == ofs);
    endfunction : hit

    nco_edge_pick u_edge (
        .clk_sys                  (clk_sys),
        .rst                      (rst),
        .clock_source_select      (cfg.clock_source_select),
        .external_clock_pin       (external_clock_pin),
        .internal_fast_oscillator (internal_fast_oscillator),
        .logic_cell_output        (logic_cell_output),
        .tick                     (tick)
    );

    // Any software byte write to the accumulator in this cycle
    assign acc_wr = hit(req, `NCO_OFS_ACCL) || hit(req, `NCO_OFS_ACCH) ||
                    hit(req, `NCO_OFS_ACCU);

    // Sleep is deliberately ignored: counting keeps going
    assign sum = {1'b0, acc_reg} + {5'h00, step_reg};
    // A tick lost to a software write must not raise a false overflow
    assign ovf = cfg.enable && tick && !acc_wr &&
                 sum[`NCO_ACC_MSB + 1];

    // Accumulator; software byte writes win over counting
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            acc_reg <= `NCO_RST_ACC;
        end else if (hit(req, `NCO_OFS_ACCL)) begin
            acc_reg[7:0] <= req.wdata;
        end else if (hit(req, `NCO_OFS_ACCH)) begin
            acc_reg[15:8] <= req.wdata;
        end else if (hit(req, `NCO_OFS_ACCU)) begin
            acc_reg[19:16] <= req.wdata[`NCO_UPPER_MSB:0];
        end else if (cfg.enable && tick) begin
            acc_reg <= sum[`NCO_ACC_MSB:0];
        end
    end

    // Step value
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            step_reg <= `NCO_RST_STEP;
        end else if (hit(req, `NCO_OFS_STEPL)) begin
            step_reg[7:0] <= req.wdata;
        end else if (hit(req, `NCO_OFS_STEPH)) begin
            step_reg[15:8] <= req.wdata;
        end
    end

    // Control and clock setup; unimplemented and read-only bits dropped
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl_reg   <= `NCO_RST_BYTE;
            clkset_reg <= `NCO_RST_BYTE;
        end else begin
            if (hit(req, `NCO_OFS_CTRL)) begin
                ctrl_reg <= req.wdata & `NCO_CTRL_WMASK;
            end
            if (hit(req, `NCO_OFS_CLKSET)) begin
                clkset_reg <= req.wdata & `NCO_CLK_WMASK;
            end
        end
    end

    // Overflow flag is sticky, write one clears, set wins over clear
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            flag_reg <= 1'b0;
            mask_reg <= 1'b0;
        end else begin
            if (ovf) begin
                flag_reg <= 1'b1;
            end else if (hit(req, `NCO_OFS_IRQ) &&
                         req.wdata[`NCO_IRQ_FLAG]) begin
                flag_reg <= 1'b0;
            end
            if (hit(req, `NCO_OFS_IRQ)) begin
                mask_reg <= req.wdata[`NCO_IRQ_MASK];
            end
        end
    end

    assign irq = flag_reg && mask_reg;

    nco_pulse u_pulse (
        .clk_sys (clk_sys),
        .rst     (rst),
        .tick    (tick),
        .ovf     (ovf),
        .pfm     (cfg.pulse_frequency_mode),
        .pws     (cfg.pulse_width_select),
        .enable  (cfg.enable),
        .level   (level)
    );

    // Polarity set inverts the active level
    assign out_level    = level ^ cfg.output_polarity;
    assign osc_out      = out_level;
    assign osc_out_oe_n = ~(cfg.enable && cfg.pin_drive_enable);

    // Read mux; live output level appears in the control byte
    always_comb begin
        rdata_next = 8'h00;
        case (req.addr)
            `NCO_OFS_ACCL:  rdata_next = acc_reg[7:0];
            `NCO_OFS_ACCH:  rdata_next = acc_reg[15:8];
            `NCO_OFS_ACCU:  rdata_next = {4'h0, acc_reg[19:16]};
            `NCO_OFS_STEPL: rdata_next = step_reg[7:0];
            `NCO_OFS_STEPH: rdata_next = step_reg[15:8];
            `NCO_OFS_CTRL: begin
                rdata_next = ctrl_reg;
                rdata_next[`NCO_CTRL_OUT] = out_level;
            end
            `NCO_OFS_CLKSET: rdata_next = clkset_reg;
            `NCO_OFS_IRQ: begin
                rdata_next[`NCO_IRQ_FLAG] = flag_reg;
                rdata_next[`NCO_IRQ_MASK] = mask_reg;
            end
            default: rdata_next = 8'h00;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (req.rd) begin
            reg_rdata <= rdata_next;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // Properties below guard the register map, counting and the flag

    // Step comes out of reset as one
    a_step_reset: assert property (@(posedge clk_sys)
        rst |=> step_reg == `NCO_RST_STEP)
        else $error("step not one after reset");

    // Upper byte reads back its nibble with zeros above
    a_upper_zero: assert property (@(posedge clk_sys) disable iff (rst)
        $past(req.rd) && $past(req.addr) == `NCO_OFS_ACCU |->
            reg_rdata == {4'h0, $past(acc_reg[19:16])})
        else $error("upper accumulator nibble not zero");

    // Enabled tick with no write adds the step
    a_acc_adds: assert property (@(posedge clk_sys) disable iff (rst)
        cfg.enable && tick && !req.wr |=>
            acc_reg == $past(sum[`NCO_ACC_MSB:0]))
        else $error("accumulator did not add step");

    // Overflow always leaves the flag set
    a_flag_on_ovf: assert property (@(posedge clk_sys) disable iff (rst)
        ovf |=> flag_reg)
        else $error("overflow did not set flag");

    // Disabled and unwritten accumulator holds still
    a_acc_hold: assert property (@(posedge clk_sys) disable iff (rst)
        !cfg.enable && !req.wr |=> $stable(acc_reg))
        else $error("accumulator moved while disabled");

    // Step high byte takes the written data
    a_step_write: assert property (@(posedge clk_sys) disable iff (rst)
        req.wr && req.addr == `NCO_OFS_STEPH |=>
            step_reg[15:8] == $past(req.wdata))
        else $error("step high byte not written");

    // Fixed duty output only moves on overflow, mode change or disable
    a_fdc_mode: assert property (@(posedge clk_sys) disable iff (rst)
        !cfg.pulse_frequency_mode && !ovf |=> $stable(level) or
            $changed(cfg.pulse_frequency_mode) or !cfg.enable)
        else $error("fixed duty output moved without overflow");

    // Reset clears the accumulator and the control byte
    a_acc_reset: assert property (@(posedge clk_sys)
        rst |=> acc_reg == `NCO_RST_ACC && ctrl_reg == `NCO_RST_BYTE)
        else $error("accumulator not cleared by reset");

    // Low accumulator byte takes its own write
    a_acc_lo_wr: assert property (@(posedge clk_sys)
        disable iff (rst)
        hit(req, `NCO_OFS_ACCL) |=> acc_reg[7:0] == $past(req.wdata))
        else $error("accumulator low byte not written");

    // High accumulator byte takes its own write
    a_acc_hi_wr: assert property (@(posedge clk_sys)
        disable iff (rst)
        hit(req, `NCO_OFS_ACCH) |=> acc_reg[15:8] == $past(req.wdata))
        else $error("accumulator high byte not written");

    // Only the low nibble of an upper byte write is kept
    a_acc_up_wr: assert property (@(posedge clk_sys)
        disable iff (rst)
        hit(req, `NCO_OFS_ACCU) |=>
            acc_reg[19:16] == $past(req.wdata[`NCO_UPPER_MSB:0]))
        else $error("accumulator upper nibble not written");

    // Step low byte takes the written data
    a_step_lo_wr: assert property (@(posedge clk_sys)
        disable iff (rst)
        hit(req, `NCO_OFS_STEPL) |=> step_reg[7:0] == $past(req.wdata))
        else $error("step low byte not written");

    // Step changes only when software writes it
    a_step_stable: assert property (@(posedge clk_sys)
        disable iff (rst)
        !hit(req, `NCO_OFS_STEPL) && !hit(req, `NCO_OFS_STEPH) |=>
            $stable(step_reg))
        else $error("step moved without a write");

    // Sleep request has no hold on the counter
    a_sleep_counts: assert property (@(posedge clk_sys)
        disable iff (rst)
        cpu_sleep && cfg.enable && tick && !acc_wr |=>
            acc_reg == $past(sum[`NCO_ACC_MSB:0]))
        else $error("accumulator stalled during sleep");

    // System clock source adds the step on every cycle
    a_sys_counts: assert property (@(posedge clk_sys)
        disable iff (rst)
        cfg.enable && cfg.clock_source_select == `NCO_CKS_SYS &&
            !acc_wr |=> acc_reg == $past(acc_reg) + 20'($past(step_reg)))
        else $error("system clock source did not count");

    // A carry out leaves the accumulator below where it was
    a_ovf_wraps: assert property (@(posedge clk_sys)
        disable iff (rst)
        ovf |=> acc_reg < $past(acc_reg))
        else $error("overflow without accumulator wrap");

    // Writing a one clears the flag when no overflow competes
    a_flag_clear: assert property (@(posedge clk_sys)
        disable iff (rst)
        hit(req, `NCO_OFS_IRQ) && req.wdata[`NCO_IRQ_FLAG] && !ovf |=>
            !flag_reg)
        else $error("flag not cleared by write of one");

    // Flag is sticky until software clears it
    a_flag_sticky: assert property (@(posedge clk_sys)
        disable iff (rst)
        flag_reg && !(hit(req, `NCO_OFS_IRQ) &&
            req.wdata[`NCO_IRQ_FLAG]) |=> flag_reg)
        else $error("flag dropped without a clear");

    // Read data stand for one cycle only, zero otherwise
    a_read_idle: assert property (@(posedge clk_sys)
        disable iff (rst)
        !req.rd |=> reg_rdata == `NCO_RST_BYTE)
        else $error("read data stood past its cycle");
endmodule : nco_phase_accumulator_regs

// ==== core/nco_pkg.sv ====
// Types shared by the oscillator block
package nco_pkg;
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } nco_bus_req_t;

    typedef struct packed {
        logic       enable;
        logic       pin_drive_enable;
        logic       output_polarity;
        logic       pulse_frequency_mode;
        logic [2:0] pulse_width_select;
        logic [1:0] clock_source_select;
    } nco_cfg_t;

    typedef enum logic [1:0] {
        NCO_PW_IDLE,
        NCO_PW_HIGH
    } nco_pw_state_t;
endpackage : nco_pkg

// ==== core/nco_pulse.sv ====
// Output pulse timer for pulse-frequency mode
`include "nco_params.svh"
module nco_pulse (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       tick,
    input  wire logic       ovf,
    input  wire logic       pfm,
    input  wire logic [2:0] pws,
    input  wire logic       enable,
    output logic            level
);
    nco_pkg::nco_pw_state_t state_reg;
    logic [7:0] cnt_reg;
    logic       fdc_reg;

    // Width in ticks is two to the power of the field
    function automatic logic [7:0] pw_len(input logic [2:0] sel);
        pw_len = 8'h01 << sel;
    endfunction : pw_len

    // Pulse state machine; counts ticks of the selected clock
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_reg <= nco_pkg::NCO_PW_IDLE;
            cnt_reg   <= 8'h00;
        end else if (!enable || !pfm) begin
            state_reg <= nco_pkg::NCO_PW_IDLE;
            cnt_reg   <= 8'h00;
        end else begin
            case (state_reg)
                nco_pkg::NCO_PW_IDLE: begin
                    if (ovf) begin
                        state_reg <= nco_pkg::NCO_PW_HIGH;
                        cnt_reg   <= 8'h01;
                    end
                end
                nco_pkg::NCO_PW_HIGH: begin
                    // Retrigger restarts; undefined use by software anyway
                    if (ovf) begin
                        cnt_reg <= 8'h01;
                    end else if (tick) begin
                        if (cnt_reg == pw_len(pws)) begin
                            state_reg <= nco_pkg::NCO_PW_IDLE;
                        end else begin
                            cnt_reg <= cnt_reg + 8'h01;
                        end
                    end
                end
                default: state_reg <= nco_pkg::NCO_PW_IDLE;
            endcase
        end
    end

    // Fixed duty: overflow toggles the output
    always_ff @(posedge clk_sys) begin
        if (rst || !enable) begin
            fdc_reg <= 1'b0;
        end else if (ovf && !pfm) begin
            fdc_reg <= ~fdc_reg;
        end
    end

    // Width field only reaches output in pulse mode
    assign level = pfm ? (state_reg == nco_pkg::NCO_PW_HIGH)
                       : fdc_reg;
endmodule : nco_pulse

// ==== tb/test_nco_phase_accumulator_regs.sv ====
// Self-checking bench for the oscillator register block
`include "nco_params.svh"
module test_nco_phase_accumulator_regs;
    timeunit 1ns;
    timeprecision 1ps;

    logic       clk_sys      = 1'b0;
    logic       rst          = 1'b1;
    logic [2:0] reg_addr     = 3'h0;
    logic [7:0] reg_wdata    = 8'h00;
    logic       reg_wr       = 1'b0;
    logic       reg_rd       = 1'b0;
    logic [7:0] reg_rdata;
    logic [2:0] src          = 3'h0;  // Pin, fast oscillator, logic cell
    logic       cpu_sleep    = 1'b0;
    logic       osc_out;
    logic       osc_out_oe_n;
    logic       irq;
    int         mismatches   = 0;
    int         n_checks     = 0;
    int         cyc          = 0;
    logic [7:0] lfsr         = 8'h3F;
    logic [7:0] rst_tab [8]  = '{8'h00, 8'h00, 8'h00, 8'h01,
                                 8'h00, 8'h00, 8'h00, 8'h00};

    nco_phase_accumulator_regs u_nco_phase_accumulator_regs (
        .clk_sys                  (clk_sys),
        .rst                      (rst),
        .reg_addr                 (reg_addr),
        .reg_wdata                (reg_wdata),
        .reg_wr                   (reg_wr),
        .reg_rd                   (reg_rd),
        .reg_rdata                (reg_rdata),
        .external_clock_pin       (src[0]),
        .internal_fast_oscillator (src[1]),
        .logic_cell_output        (src[2]),
        .cpu_sleep                (cpu_sleep),
        .osc_out                  (osc_out),
        .osc_out_oe_n             (osc_out_oe_n),
        .irq                      (irq)
    );

    // 50 MHz system clock
    always #10 clk_sys = ~clk_sys;

    // Cut a hung run short; far above the fewer than a thousand cycles needed
    always @(posedge clk_sys) begin
        cyc = cyc + 1;
        if (cyc == 30000) begin
            mismatches++;
            test_done();
        end
    end

    task automatic test_done();
        if (mismatches == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done

    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr_next

    task automatic rnd(output logic [7:0] v);
        lfsr = lfsr_next(lfsr);
        v    = lfsr;
    endtask : rnd

    task automatic chk(input string name, input logic [19:0] seen,
                       input logic [19:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s exp %h seen %h", name, exp, seen);
        end
    endtask : chk

    // One-cycle strobes, changed just after the edge
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
        #1; // Outputs settle before callers compare them
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    task automatic rd_chk(input string name, input logic [2:0] a,
                          input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk(name, {12'h000, d}, {12'h000, exp});
    endtask : rd_chk

    task automatic rd_acc(output logic [19:0] v);
        logic [7:0] b0, b1, b2;
        rd(`NCO_OFS_ACCL, b0);
        rd(`NCO_OFS_ACCH, b1);
        rd(`NCO_OFS_ACCU, b2);
        v = {b2[3:0], b1, b0};
    endtask : rd_acc

    task automatic wr_acc(input logic [19:0] v);
        wr(`NCO_OFS_ACCL, v[7:0]);
        wr(`NCO_OFS_ACCH, v[15:8]);
        wr(`NCO_OFS_ACCU, {4'h0, v[19:16]});
    endtask : wr_acc

    task automatic wr_step(input logic [15:0] v);
        wr(`NCO_OFS_STEPL, v[7:0]);
        wr(`NCO_OFS_STEPH, v[15:8]);
    endtask : wr_step

    // Rising edges on one source, spaced so the edge detector sees each
    task automatic ticks(input int sel, input int n);
        repeat (n) begin
            @(posedge clk_sys);
            src[sel] <= 1'b1;
            @(posedge clk_sys);
            src[sel] <= 1'b0;
            @(posedge clk_sys);
        end
        repeat (4) @(posedge clk_sys);
    endtask : ticks

    // Accumulator after n enabled ticks, wrapping at twenty bits
    function automatic logic [19:0] acc_after(input logic [19:0] a,
                                              input logic [15:0] s,
                                              input int n);
        return a + 20'(s) * 20'(n);
    endfunction : acc_after

    task automatic do_reset();
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
    endtask : do_reset

    // Main sequence
    initial begin
        logic [7:0]  d, b, c;
        logic [19:0] a, e;
        logic [15:0] st;
        int          n;
        logic [1:0]  codes [3] = '{2'h0, 2'h2, 2'h3};
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        chk("oe_n_reset", 20'(osc_out_oe_n), 20'h00001);
        for (int i = 0; i < 8; i++) begin
            rd_chk("reset_value", 3'(i), rst_tab[i]);
        end
        // Random byte round trips, upper nibble masking
        repeat (4) begin
            rnd(d);
            rnd(b);
            rnd(c);
            a = {c[3:0], b, d};
            wr_acc(a);
            rd_acc(e);
            chk("acc_rw", e, a);
            wr_step({c, d});
            rd_chk("step_low", `NCO_OFS_STEPL, d);
            rd_chk("step_high", `NCO_OFS_STEPH, c);
        end
        wr(`NCO_OFS_ACCU, 8'hFF);
        rd_chk("acc_upper", `NCO_OFS_ACCU, 8'h0F);
        // Idle pulse output is low, so set polarity reads back high
        wr(`NCO_OFS_CTRL, 8'hFF);
        rd_chk("ctrl_rw", `NCO_OFS_CTRL, 8'hF1);
        chk("oe_n_on", 20'(osc_out_oe_n), 20'h00000);
        wr(`NCO_OFS_CTRL, 8'h00);
        wr(`NCO_OFS_CLKSET, 8'hFF);
        rd_chk("clk_rw", `NCO_OFS_CLKSET, 8'hE3);
        // Count on each edge source; the next source toggles and must not count
        cpu_sleep <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            rnd(d);
            rnd(b);
            rnd(c);
            a  = {c[3:0], b, d};
            st = {b, c};
            wr_acc(a);
            wr_step(st);
            wr(`NCO_OFS_CLKSET, {6'h00, codes[i]});
            wr(`NCO_OFS_CTRL, 8'h80);
            ticks(i, 5);
            ticks((i + 1) % 3, 3);
            wr(`NCO_OFS_CTRL, 8'h00);
            rd_acc(e);
            chk("count", e, acc_after(a, st, 5));
        end
        // System clock source counts every cycle
        wr(`NCO_OFS_CLKSET, 8'h01);
        wr_acc(20'h00000);
        wr_step(16'h0001);
        wr(`NCO_OFS_CTRL, 8'h80);
        repeat (10) @(posedge clk_sys);
        wr(`NCO_OFS_CTRL, 8'h00);
        rd_acc(e);
        chk("sys_count", 20'(e >= 20'd8 && e <= 20'd16), 20'h00001);
        cpu_sleep <= 1'b0;
        // Overflow sets the flag; mask gates the line; fixed duty toggles
        do_reset();
        wr_acc(20'hFFFFF);
        wr(`NCO_OFS_CTRL, 8'hC0);
        ticks(0, 1);
        rd_acc(e);
        chk("wrap", e, 20'h00000);
        rd_chk("flag_set", `NCO_OFS_IRQ, 8'h01);
        chk("irq_masked", 20'(irq), 20'h00000);
        chk("fixed_out", 20'(osc_out), 20'h00001);
        rd_chk("out_level", `NCO_OFS_CTRL, 8'hE0);
        wr(`NCO_OFS_IRQ, 8'h10);
        chk("irq_on", 20'(irq), 20'h00001);
        wr(`NCO_OFS_IRQ, 8'h11);
        chk("irq_off", 20'(irq), 20'h00000);
        rd_chk("flag_clr", `NCO_OFS_IRQ, 8'h10);
        // Width of one tick would end a pulse; fixed duty must ignore it
        ticks(0, 2);
        chk("fixed_hold", 20'(osc_out), 20'h00001);
        wr(`NCO_OFS_CTRL, 8'hD0);
        chk("polarity", 20'(osc_out), 20'h00000);
        // Pulse mode widths; overflow every 32 ticks keeps width legal
        for (int p = 0; p < 5; p++) begin
            do_reset();
            wr_step(16'h8000);
            wr_acc(20'hF8000);
            wr(`NCO_OFS_CLKSET, {3'(p), 5'h00});
            wr(`NCO_OFS_CTRL, 8'h81);
            ticks(0, 1);
            chk("pulse_start", 20'(osc_out), 20'h00001);
            n = 0;
            while (osc_out === 1'b1 && n < 300) begin
                ticks(0, 1);
                n++;
            end
            chk("pulse_len", 20'(n), 20'(1 << p));
        end
        test_done();
    end
endmodule : test_nco_phase_accumulator_regs
